// [pkg/i2cw_pkg.sv]
// package: register map, field positions, reset values and state types of the i2c config block
package i2cw_pkg;

  // register addresses as printed (byte-wide registers)
  localparam logic [19:0] CTL2_OFS = 20'hf0231;
  localparam logic [19:0] WL_OFS = 20'hf0232;
  localparam logic [19:0] WH_OFS = 20'hf0233;
  localparam logic [19:0] PM_OFS = 20'hfff26;

  // control two field positions
  localparam int unsigned WUP_BIT = 7;
  localparam int unsigned CLD_BIT = 5;
  localparam int unsigned DAD_BIT = 4;
  localparam int unsigned SMC_BIT = 3;
  localparam int unsigned DFC_BIT = 2;
  localparam int unsigned PRS_BIT = 0;
  localparam logic [7:0] CTL2_WMASK = 8'h8d;

  // direction register fields
  localparam int unsigned PM_SCL_BIT = 0;
  localparam int unsigned PM_SDA_BIT = 1;
  localparam logic [5:0] PM_UPPER = 6'h3f;

  // reset values
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [7:0] WL_RST = 8'hff;
  localparam logic [7:0] WH_RST = 8'hff;
  localparam logic [1:0] PM_RST = 2'h3;

  // operation-clock cycles the wakeup setting needs before stop mode
  localparam logic [1:0] WUP_SETTLE_CYC = 2'h3;

  // generated serial clock phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_LOW = 2'b01,
    PH_HIGH = 2'b10
  } i2cw_phase_t;

  // all state of the block
  typedef struct packed {
    logic [7:0] ctl2;
    logic [7:0] wl;
    logic [7:0] wh;
    logic [1:0] pm;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_f;
    logic sda_f;
    logic cld;
    logic dad;
    logic div;
    logic tick;
    i2cw_phase_t phase;
    logic [7:0] cnt;
    logic scl_oe;
    logic sda_oe;
    logic drv_lvl;
    logic start_det;
    logic start_p;
    logic stop_p;
    logic stop_irq;
    logic match_irq;
    logic wake;
    logic irq_seen;
    logic master_block;
    logic [1:0] settle;
    logic settled;
    logic [7:0] rdata;
  } i2cw_state_t;

  localparam i2cw_state_t ST_RST = '{
    ctl2: CTL2_RST, wl: WL_RST, wh: WH_RST, pm: PM_RST,
    scl_s: 2'h3, sda_s: 2'h3, scl_f: 1'b1, sda_f: 1'b1,
    phase: PH_IDLE, cnt: 8'h00, rdata: 8'h00,
    settle: 2'h0, default: 1'b0};

  // address decode used by both the write and read paths
  function automatic logic i2cw_hit(input logic [19:0] addr, input logic [19:0] ofs);
    return addr == ofs;
  endfunction

endpackage

// [rtl/i2cw_cfg.sv]
// module: i2c mode, wakeup, clock width and pin direction configuration
//
// Strobed register access was chosen for this implementation.
module i2cw_cfg
  import i2cw_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  input wire logic [19:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic controller_enable_i,
  input wire logic stop_irq_enable_i,
  input wire logic match_event_i,
  input wire logic gen_run_i,
  input wire logic sda_drive_low_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic opclk_tick_o,
  output logic fast_mode_o,
  output logic noise_filter_en_o,
  output logic wakeup_en_o,
  output logic wakeup_ready_o,
  output logic start_detected_flag_o,
  output logic stop_irq_o,
  output logic match_irq_o,
  output logic wake_o,
  output logic master_blocked_o
);

  i2cw_state_t st_q;
  i2cw_state_t st_d;

  // two-sample noise filter: the level only moves when both samples agree
  function automatic logic filt(input logic [1:0] hist, input logic held, input logic on);
    if (!on) begin
      return hist[0];
    end
    return (hist[1] == hist[0]) ? hist[0] : held;
  endfunction

  // next state of everything
  always_comb begin
    logic en;
    logic tk;
    logic wr_ctl2;
    logic nscl;
    logic nsda;
    en = controller_enable_i;
    tk = 1'b0;
    wr_ctl2 = 1'b0;
    nscl = 1'b1;
    nsda = 1'b1;
    st_d = st_q;
    if (clk_en_i) begin
      // operation clock: full rate or every second cycle
      tk = !st_q.ctl2[PRS_BIT] || st_q.div;
      st_d.div = !st_q.div;
      st_d.tick = tk;

      // pin sampling and optional filtering; the filter only cleans inputs
      // and never touches the clock counter, so the rate stays fixed
      st_d.scl_s = {st_q.scl_s[0], scl_i};
      st_d.sda_s = {st_q.sda_s[0], sda_i};
      nscl = filt(st_q.scl_s, st_q.scl_f, st_q.ctl2[DFC_BIT]);
      nsda = filt(st_q.sda_s, st_q.sda_f, st_q.ctl2[DFC_BIT]);
      st_d.scl_f = nscl;
      st_d.sda_f = nsda;

      // pin level flags, forced low while disabled
      st_d.cld = en && nscl;
      st_d.dad = en && nsda;

      // start and stop conditions on the filtered lines
      st_d.start_p = en && st_q.scl_f && nscl && st_q.sda_f && !nsda;
      st_d.stop_p = en && st_q.scl_f && nscl && !st_q.sda_f && nsda;
      if (!en) begin
        st_d.start_det = 1'b0;
      end else if (st_d.start_p) begin
        st_d.start_det = 1'b1;
      end else if (st_d.stop_p) begin
        st_d.start_det = 1'b0;
      end

      // interrupts: stop muted while waking, match unchanged either way
      st_d.stop_irq = st_d.stop_p && stop_irq_enable_i && !st_q.ctl2[WUP_BIT];
      st_d.match_irq = match_event_i;
      st_d.wake = match_event_i && st_q.ctl2[WUP_BIT];
      if (match_event_i && st_q.ctl2[WUP_BIT]) begin
        st_d.irq_seen = 1'b1;
      end

      // wakeup settle count, in operation clocks
      if (st_q.ctl2[WUP_BIT] && !st_q.settled && tk) begin
        st_d.settle = 2'(st_q.settle + 2'h1);
        st_d.settled = (2'(st_q.settle + 2'h1) == WUP_SETTLE_CYC);
      end

      // master block is lifted by the next start or stop condition
      if (st_d.start_p || st_d.stop_p) begin
        st_d.master_block = 1'b0;
      end

      // register writes
      wr_ctl2 = reg_wr_i && i2cw_hit(reg_addr_i, CTL2_OFS);
      if (wr_ctl2) begin
        st_d.ctl2[WUP_BIT] = reg_wdata_i[WUP_BIT];
        if (!en) begin
          st_d.ctl2 = reg_wdata_i & CTL2_WMASK;
        end
        if (reg_wdata_i[WUP_BIT] && !st_q.ctl2[WUP_BIT]) begin
          st_d.settle = 2'h0;
          st_d.settled = 1'b0;
          st_d.irq_seen = 1'b0;
        end
        if (!reg_wdata_i[WUP_BIT] && st_q.ctl2[WUP_BIT] && !st_q.irq_seen) begin
          st_d.master_block = 1'b1;
        end
        if (!reg_wdata_i[WUP_BIT]) begin
          st_d.settled = 1'b0;
        end
      end
      if (reg_wr_i && !en && i2cw_hit(reg_addr_i, WL_OFS)) begin
        st_d.wl = reg_wdata_i;
      end
      if (reg_wr_i && !en && i2cw_hit(reg_addr_i, WH_OFS)) begin
        st_d.wh = reg_wdata_i;
      end
      if (reg_wr_i && i2cw_hit(reg_addr_i, PM_OFS)) begin
        st_d.pm = reg_wdata_i[1:0];
      end

      // serial clock generator, low then high, each counted in opclk ticks
      if (!en || !gen_run_i) begin
        st_d.phase = PH_IDLE;
        st_d.cnt = 8'h00;
      end else begin
        unique case (st_q.phase)
          PH_IDLE: begin
            st_d.phase = PH_LOW;
            st_d.cnt = 8'h00;
          end
          PH_LOW: begin
            if (tk) begin
              if (st_q.cnt >= st_q.wl) begin
                st_d.phase = PH_HIGH;
                st_d.cnt = 8'h00;
              end else begin
                st_d.cnt = 8'(st_q.cnt + 8'h01);
              end
            end
          end
          PH_HIGH: begin
            if (tk) begin
              if (st_q.cnt >= st_q.wh) begin
                st_d.phase = PH_LOW;
                st_d.cnt = 8'h00;
              end else begin
                st_d.cnt = 8'(st_q.cnt + 8'h01);
              end
            end
          end
          default: begin
            st_d.phase = PH_IDLE;
            st_d.cnt = 8'h00;
          end
        endcase
      end

      // open-drain drive: only low is ever driven, and only in output mode
      st_d.drv_lvl = 1'b0;
      st_d.scl_oe = !st_q.pm[PM_SCL_BIT] && (!en || st_q.phase == PH_LOW);
      st_d.sda_oe = !st_q.pm[PM_SDA_BIT] && (!en || sda_drive_low_i);

      // read data stands in the cycle after the strobe and holds while clk_en_i is low
      st_d.rdata = 8'h00;
      if (reg_rd_i) begin
        if (i2cw_hit(reg_addr_i, CTL2_OFS)) begin
          st_d.rdata = st_q.ctl2 & CTL2_WMASK;
          st_d.rdata[CLD_BIT] = st_q.cld;
          st_d.rdata[DAD_BIT] = st_q.dad;
        end else if (i2cw_hit(reg_addr_i, WL_OFS)) begin
          st_d.rdata = st_q.wl;
        end else if (i2cw_hit(reg_addr_i, WH_OFS)) begin
          st_d.rdata = st_q.wh;
        end else if (i2cw_hit(reg_addr_i, PM_OFS)) begin
          st_d.rdata = {PM_UPPER, st_q.pm};
        end
      end
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign reg_rdata_o = st_q.rdata;
  assign scl_o = st_q.drv_lvl;
  assign scl_oe_o = st_q.scl_oe;
  assign sda_o = st_q.drv_lvl;
  assign sda_oe_o = st_q.sda_oe;
  assign opclk_tick_o = st_q.tick;
  assign fast_mode_o = st_q.ctl2[SMC_BIT];
  assign noise_filter_en_o = st_q.ctl2[DFC_BIT];
  assign wakeup_en_o = st_q.ctl2[WUP_BIT];
  assign wakeup_ready_o = st_q.settled;
  assign start_detected_flag_o = st_q.start_det;
  assign stop_irq_o = st_q.stop_irq;
  assign match_irq_o = st_q.match_irq;
  assign wake_o = st_q.wake;
  assign master_blocked_o = st_q.master_block;

  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  a_stop_irq_mute: assert property (
    stop_irq_o |-> !$past(st_q.ctl2[WUP_BIT]))
    else $error("stop interrupt raised while wakeup set");
  a_match_irq_time: assert property (
    clk_en_i && match_event_i |=> match_irq_o)
    else $error("match interrupt not one cycle after event");
  a_wake_cause: assert property (
    wake_o |-> $past(st_q.ctl2[WUP_BIT]) && $past(match_event_i))
    else $error("wake without enabled match");
  a_clock_flag_off: assert property (
    clk_en_i && !controller_enable_i |=> !st_q.cld)
    else $error("clock level flag set while disabled");
  a_data_flag_level: assert property (
    clk_en_i && controller_enable_i && !st_q.ctl2[DFC_BIT] |=> st_q.dad == $past(st_q.sda_s[0]))
    else $error("data level flag does not follow pin");
  a_width_locked: assert property (
    clk_en_i && controller_enable_i && reg_wr_i && reg_addr_i == WL_OFS |=> $stable(st_q.wl))
    else $error("low width changed while enabled");
  a_mode_locked: assert property (
    clk_en_i && controller_enable_i && reg_wr_i && reg_addr_i == CTL2_OFS
    |=> $stable(st_q.ctl2[SMC_BIT]))
    else $error("speed bit changed while enabled");
  a_pin_low_off: assert property (
    clk_en_i && !controller_enable_i && !st_q.pm[PM_SCL_BIT] |=> scl_oe_o)
    else $error("clock pin not driven low while disabled");
  a_input_mode: assert property (
    scl_oe_o |-> !$past(st_q.pm[PM_SCL_BIT]))
    else $error("clock pin driven in input mode");
  a_pm_upper_ones: assert property (
    clk_en_i && reg_rd_i && reg_addr_i == PM_OFS |=> reg_rdata_o[7:2] == 6'h3f)
    else $error("direction upper bits not one");
  a_low_phase_len: assert property (
    st_q.phase == PH_LOW |-> st_q.cnt <= st_q.wl)
    else $error("low phase count past width");
  a_start_flag_set: assert property (
    st_q.start_p |-> st_q.start_det)
    else $error("start detected flag missing after start");
  a_data_flag_off: assert property (
    clk_en_i && !controller_enable_i |=> !st_q.dad)
    else $error("data level flag set while disabled");
  a_high_width_lock: assert property (
    clk_en_i && controller_enable_i && reg_wr_i && reg_addr_i == WH_OFS |=> $stable(st_q.wh))
    else $error("high width changed while enabled");
  a_tick_full_rate: assert property (
    rstn_i && clk_en_i && !st_q.ctl2[PRS_BIT] |=> opclk_tick_o)
    else $error("operation clock tick missing at full rate");
  a_sda_input_mode: assert property (
    sda_oe_o |-> !$past(st_q.pm[PM_SDA_BIT]))
    else $error("data pin driven in input mode");
  a_high_phase_len: assert property (
    st_q.phase == PH_HIGH |-> st_q.cnt <= st_q.wh)
    else $error("high phase count past width");

endmodule // i2cw_cfg

// [dv/i2cw_bus_peer.sv]
// bus peer model: another master on the open-drain wire, pull-ups on both lines
module i2cw_bus_peer (
  input wire logic clk_i,
  input wire logic scl_pull_i,
  input wire logic sda_pull_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // wired-and: a released line goes to its pull-up level
  assign scl_o = ~(scl_low | scl_pull_i);
  assign sda_o = ~(sda_low | sda_pull_i);
  // one bus step lasts five system clocks
  task automatic step(input logic c, input logic d);
    @(posedge clk_i);
    scl_low <= c;
    sda_low <= d;
    repeat (4) @(posedge clk_i);
  endtask
  // data falls while clock is high, then clock goes low
  task automatic gen_start();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
  endtask
  // data rises while clock is high
  task automatic gen_stop();
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
  endtask
endmodule // i2cw_bus_peer

// [dv/test_i2cw_cfg.sv]
// testbench: register map, pin flags, events and clock generation of the config block
module test_i2cw_cfg
  import i2cw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, en = 1'b0;
  logic spie = 1'b0, mev = 1'b0, run = 1'b0, rd_q = 1'b0, sdl = 1'b0, ce = 1'b1;
  logic scl_dv, sda_dv;
  logic [19:0] addr = 20'h00000;
  logic [7:0] wdat = 8'h00, rdat, mq, r1, r2;
  logic scl, sda, scl_oe, sda_oe, tick, fast, filt, wup, wrdy, std, spi, mirq, wake, mblk;
  logic [31:0] seed = 32'h282d;
  logic [7:0] expq[$];
  int errors = 0, checked = 0, n_stop = 0, n_match = 0, n_wake = 0, n_tick = 0;
  int lo, hi, s0, k;

  i2cw_cfg i2cw_cfg_inst (.clk_sys_i(clk), .rstn_i(rstn), .clk_en_i(ce),
    .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .controller_enable_i(en), .stop_irq_enable_i(spie), .match_event_i(mev),
    .gen_run_i(run), .sda_drive_low_i(sdl), .scl_i(scl), .sda_i(sda), .scl_o(scl_dv),
    .scl_oe_o(scl_oe), .sda_o(sda_dv), .sda_oe_o(sda_oe), .opclk_tick_o(tick),
    .fast_mode_o(fast), .noise_filter_en_o(filt), .wakeup_en_o(wup),
    .wakeup_ready_o(wrdy), .start_detected_flag_o(std), .stop_irq_o(spi),
    .match_irq_o(mirq), .wake_o(wake), .master_blocked_o(mblk));
  i2cw_bus_peer i2cw_bus_peer_inst (.clk_i(clk), .scl_pull_i(scl_oe), .sda_pull_i(sda_oe),
    .scl_o(scl), .sda_o(sda));

  initial begin
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // expected read data is queued; the monitor compares it in the answer cycle
  task automatic rd_reg(input logic [19:0] a, input logic [7:0] e);
    expq.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  task automatic evt(input logic [7:0] em, input logic [7:0] ew);
    int m0, w0;
    m0 = n_match;
    w0 = n_wake;
    @(posedge clk);
    mev <= 1'b1;
    @(posedge clk);
    mev <= 1'b0;
    cyc(3);
    chk(8'(n_match - m0), em);
    chk(8'(n_wake - w0), ew);
  endtask

  // length of one low and one high phase of the generated clock
  task automatic meas();
    k = 0;
    lo = 0;
    hi = 0;
    while (scl_oe !== 1'b0 && k < 600) begin @(posedge clk); k++; end
    while (scl_oe !== 1'b1 && k < 600) begin @(posedge clk); k++; end
    while (scl_oe === 1'b1 && lo < 600) begin @(posedge clk); lo++; end
    while (scl_oe === 1'b0 && hi < 600) begin @(posedge clk); hi++; end
  endtask

  task automatic end_sim();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // read answers are checked one cycle after the strobe
  always @(posedge clk) begin
    if (rd_q) begin
      mq = expq.pop_front();
      chk(rdat, mq);
    end
    rd_q <= rd;
  end

  // pulse counters, sampled mid-cycle
  always @(negedge clk) begin
    n_stop += int'(spi === 1'b1);
    n_match += int'(mirq === 1'b1);
    n_wake += int'(wake === 1'b1);
    n_tick += int'(tick === 1'b1);
  end

  initial begin
    #(50 * 20000);
    errors++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(CTL2_OFS, 8'h00);
    rd_reg(WL_OFS, 8'hff);
    rd_reg(WH_OFS, 8'hff);
    rd_reg(PM_OFS, 8'hff);
    rd_reg(20'h00000, 8'h00);
    wr_reg(CTL2_OFS, 8'hff);
    rd_reg(CTL2_OFS, 8'h8d);
    chk({wup, fast, filt}, 8'h07);
    seed = lfsr(seed);
    r1 = seed[7:0];
    seed = lfsr(seed);
    r2 = seed[7:0];
    wr_reg(WL_OFS, r1);
    wr_reg(WH_OFS, r2);
    rd_reg(WL_OFS, r1);
    rd_reg(WH_OFS, r2);
    wr_reg(PM_OFS, 8'h00);
    cyc(3);
    chk({scl_oe, sda_oe}, 8'h03);
    wr_reg(PM_OFS, 8'hff);
    cyc(3);
    chk({scl_oe, sda_oe}, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr_reg(CTL2_OFS, 8'(i));
      cyc(2);
      s0 = n_tick;
      cyc(20);
      chk(8'(n_tick - s0), 8'(20 >> i));
    end
    wr_reg(CTL2_OFS, 8'h00);
    en <= 1'b1;
    wr_reg(WL_OFS, ~r1);
    rd_reg(WL_OFS, r1);
    wr_reg(CTL2_OFS, 8'h0d);
    cyc(4);
    rd_reg(CTL2_OFS, 8'h30);
    // wakeup was cleared earlier with no match seen: block stands until a start or stop
    chk(mblk, 8'h01);
    i2cw_bus_peer_inst.gen_stop();
    chk(mblk, 8'h00);
    wr_reg(CTL2_OFS, 8'h80);
    cyc(5);
    chk({wup, wrdy}, 8'h03);
    evt(8'h01, 8'h01);
    wr_reg(CTL2_OFS, 8'h00);
    cyc(2);
    chk(mblk, 8'h00);
    wr_reg(CTL2_OFS, 8'h80);
    cyc(5);
    spie <= 1'b1;
    s0 = n_stop;
    i2cw_bus_peer_inst.gen_start();
    i2cw_bus_peer_inst.gen_stop();
    cyc(5);
    chk(8'(n_stop - s0), 8'h00);
    wr_reg(CTL2_OFS, 8'h00);
    cyc(2);
    chk(mblk, 8'h01);
    i2cw_bus_peer_inst.gen_start();
    cyc(3);
    chk({std, mblk}, 8'h02);
    rd_reg(CTL2_OFS, 8'h00);
    s0 = n_stop;
    i2cw_bus_peer_inst.gen_stop();
    cyc(5);
    chk(8'(n_stop - s0), 8'h01);
    evt(8'h01, 8'h00);
    // fast mode clock, filter off then on
    for (int i = 0; i < 2; i++) begin
      en <= 1'b0;
      wr_reg(WL_OFS, 8'h02);
      wr_reg(WH_OFS, 8'h03);
      wr_reg(CTL2_OFS, 8'h08 | 8'(i << 2));
      en <= 1'b1;
      wr_reg(PM_OFS, 8'h00);
      run <= 1'b1;
      meas();
      chk(8'(lo), 8'h03);
      chk(8'(hi), 8'h04);
      // data pin is pulled only on request, and the driven level is always low
      chk(8'({sda_oe, scl_dv, sda_dv}), 8'h00);
      sdl <= 1'b1;
      cyc(3);
      chk(8'({sda_oe, scl_dv, sda_dv}), 8'h04);
      sdl <= 1'b0;
      run <= 1'b0;
      wr_reg(PM_OFS, 8'hff);
    end
    // with the clock enable low a write must not land
    en <= 1'b0;
    ce <= 1'b0;
    wr_reg(WL_OFS, 8'h55);
    ce <= 1'b1;
    rd_reg(WL_OFS, 8'h02);
    cyc(4);
    end_sim();
  end
endmodule // test_i2cw_cfg
